// file: hw/uets_defs.svh
`ifndef UETS_DEFS_SVH
`define UETS_DEFS_SVH

`define UETS_IDX_EV0_B0     14'h3A14
`define UETS_IDX_EV0_B1     14'h3A15
`define UETS_IDX_EV0_B2     14'h3A16
`define UETS_IDX_EV0_B3     14'h3A17
`define UETS_IDX_EV0_B4     14'h3A18
`define UETS_IDX_EV0_B5     14'h3A19
`define UETS_IDX_EV0_B6     14'h3A1A
`define UETS_IDX_EV0_B7     14'h3A1B
`define UETS_IDX_EV0_B8     14'h3A1C
`define UETS_IDX_EV0_B9     14'h3A1D
`define UETS_IDX_EV0_MISSED 14'h3A1E
`define UETS_IDX_EV0_QUAL   14'h3A1F
`define UETS_IDX_EV1_B0     14'h3A20
`define UETS_IDX_CTRL       14'h3A30
`define UETS_IDX_PERIOD     14'h3A31
`define UETS_IDX_TOL        14'h3A32
`define UETS_IDX_IRQ_STAT   14'h3A33
`define UETS_IDX_IRQ_MASK   14'h3A34

`define UETS_CTRL_CHECK_BIT 0
`define UETS_QUAL_LOWRES    0
`define UETS_IRQ_CAP0       0
`define UETS_IRQ_CAP1       1
`define UETS_IRQ_MISS0      2
`define UETS_IRQ_LOWRES0    3

`define UETS_CTRL_RST       32'h0000_0000
`define UETS_PERIOD_RST     32'h0000_0000
`define UETS_TOL_RST        32'h0000_0000
`define UETS_MASK_RST       4'h0
`define UETS_MISSED_MAX     8'hFF
`define UETS_RESP_OKAY      2'h0
`define UETS_RESP_SLVERR    2'h2

`endif

// file: hw/uets_pkg.sv
package uets_pkg;
    typedef logic [79:0] uets_stamp_t;
    typedef logic [31:0] uets_word_t;
    typedef logic [7:0]  uets_byte_t;
    typedef logic [3:0]  uets_irq_t;
    typedef enum logic [1:0] {
        UETS_WR_IDLE = 2'b01,
        UETS_WR_RESP = 2'b10
    } uets_wr_state_t;
    typedef enum logic [1:0] {
        UETS_RD_IDLE = 2'b01,
        UETS_RD_DATA = 2'b10
    } uets_rd_state_t;
endpackage

// file: hw/uets_channel.sv
`timescale 1ns/1ps
`include "uets_defs.svh"
module uets_channel
(
    input  wire logic               i_clk,
    input  wire logic               i_rst,
    input  wire logic               i_ce,
    input  wire logic               i_event,
    input  wire logic               i_io_update,
    input  wire logic               i_read_ack,
    input  wire uets_pkg::uets_stamp_t i_time,
    input  wire uets_pkg::uets_word_t  i_period_exp,
    input  wire uets_pkg::uets_word_t  i_period_tol,
    input  wire logic               i_check_en,
    output uets_pkg::uets_stamp_t   o_stamp,
    output logic                    o_lowres,
    output uets_pkg::uets_byte_t    o_missed,
    output logic                    o_capture,
    output logic                    o_lost,
    output logic                    o_lowres_evt
);
    import uets_pkg::*;

    logic        event_d;
    logic        pend_valid;
    uets_stamp_t pend_stamp;
    logic        pend_lowres;
    logic        active_unread;
    logic        have_last;
    uets_word_t  last_time;
    logic        edge_seen;
    uets_word_t  interval;
    logic [32:0] lim_hi;
    logic [32:0] lim_lo;
    logic        off_period;
    logic        lost_unupdated;
    logic        lost_unread;
    logic [1:0]  loss_inc;
    logic [8:0]  next_missed;

    assign edge_seen      = i_event & ~event_d;
    assign interval       = i_time[31:0] - last_time;
    assign lim_hi         = {1'b0, i_period_exp} + {1'b0, i_period_tol};
    assign lim_lo         = {1'b0, interval} + {1'b0, i_period_tol};
    assign off_period     = i_check_en & have_last
                            & (({1'b0, interval} > lim_hi) | (lim_lo < {1'b0, i_period_exp}));
    assign lost_unupdated = edge_seen & pend_valid & ~i_io_update;
    assign lost_unread    = i_io_update & pend_valid & active_unread & ~i_read_ack;
    assign loss_inc       = {1'b0, lost_unupdated} + {1'b0, lost_unread};
    assign next_missed    = {1'b0, o_missed} + {7'h00, loss_inc};

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            event_d   <= 1'b0;
            have_last <= 1'b0;
            last_time <= 32'h0000_0000;
        end
        else if (i_ce)
        begin
            event_d <= i_event;
            if (edge_seen)
            begin
                have_last <= 1'b1;
                last_time <= i_time[31:0];
            end
        end
    end

    // A new edge replaces any stamp still waiting for an update.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            pend_valid  <= 1'b0;
            pend_stamp  <= 80'h0;
            pend_lowres <= 1'b0;
        end
        else if (i_ce)
        begin
            if (edge_seen)
            begin
                pend_valid  <= 1'b1;
                pend_stamp  <= i_time;
                pend_lowres <= off_period;
            end
            else if (i_io_update)
            begin
                pend_valid <= 1'b0;
            end
        end
    end

    // Software sees a stamp only after an update moves it to the active copy.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_stamp       <= 80'h0;
            o_lowres      <= 1'b0;
            active_unread <= 1'b0;
        end
        else if (i_ce)
        begin
            if (i_io_update && pend_valid)
            begin
                o_stamp       <= pend_stamp;
                o_lowres      <= pend_lowres;
                active_unread <= 1'b1;
            end
            else if (i_read_ack)
            begin
                active_unread <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_missed     <= 8'h00;
            o_capture    <= 1'b0;
            o_lost       <= 1'b0;
            o_lowres_evt <= 1'b0;
        end
        else if (i_ce)
        begin
            o_missed     <= next_missed[8] ? `UETS_MISSED_MAX : next_missed[7:0];
            o_capture    <= edge_seen;
            o_lost       <= lost_unupdated | lost_unread;
            o_lowres_evt <= edge_seen & off_period;
        end
    end
endmodule

// file: hw/uets_top.sv
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "uets_defs.svh"
module uets_top
(
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_ce,
    input  wire logic                  i_event0,
    input  wire logic                  i_event1,
    input  wire logic                  i_io_update,
    input  wire logic [15:0]           i_axi_awaddr,
    input  wire logic                  i_axi_awvalid,
    output logic                       o_axi_awready,
    input  wire uets_pkg::uets_word_t  i_axi_wdata,
    input  wire logic [3:0]            i_axi_wstrb,
    input  wire logic                  i_axi_wvalid,
    output logic                       o_axi_wready,
    output logic [1:0]                 o_axi_bresp,
    output logic                       o_axi_bvalid,
    input  wire logic                  i_axi_bready,
    input  wire logic [15:0]           i_axi_araddr,
    input  wire logic                  i_axi_arvalid,
    output logic                       o_axi_arready,
    output uets_pkg::uets_word_t       o_axi_rdata,
    output logic [1:0]                 o_axi_rresp,
    output logic                       o_axi_rvalid,
    input  wire logic                  i_axi_rready,
    output logic                       o_irq
);
    import uets_pkg::*;

    uets_stamp_t    time_now;
    uets_stamp_t    stamp0;
    uets_stamp_t    stamp1;
    logic           lowres0;
    uets_byte_t     missed0;
    logic           cap0;
    logic           cap1;
    logic           lost0;
    logic           lowres_evt0;
    logic           read_ack0;
    logic           read_ack1;

    uets_word_t     ctrl;
    uets_word_t     period_exp;
    uets_word_t     period_tol;
    uets_irq_t      irq_stat;
    uets_irq_t      irq_mask;
    uets_irq_t      irq_set;
    uets_irq_t      irq_clr;

    uets_wr_state_t wr_state;
    uets_rd_state_t rd_state;
    logic           aw_held;
    logic           w_held;
    logic [13:0]    aw_idx;
    uets_word_t     w_data;
    logic [3:0]     w_strb;
    logic           wr_fire;
    logic           wr_known;

    logic [13:0]    rd_idx;
    logic [3:0]     rd_off;
    uets_word_t     rd_word;
    logic           rd_known;
    logic           rd_fire;

    function automatic uets_word_t apply_strb(input uets_word_t old_v,
                                              input uets_word_t new_v,
                                              input logic [3:0] strb);
        uets_word_t res;
        res = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Free-running time base that every stamp is taken from.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            time_now <= 80'h0;
        end
        else if (i_ce)
        begin
            time_now <= time_now + 80'h1;
        end
    end

    uets_channel u_chan0
    (
        .i_clk        (i_clk),
        .i_rst        (i_rst),
        .i_ce         (i_ce),
        .i_event      (i_event0),
        .i_io_update  (i_io_update),
        .i_read_ack   (read_ack0),
        .i_time       (time_now),
        .i_period_exp (period_exp),
        .i_period_tol (period_tol),
        .i_check_en   (ctrl[`UETS_CTRL_CHECK_BIT]),
        .o_stamp      (stamp0),
        .o_lowres     (lowres0),
        .o_missed     (missed0),
        .o_capture    (cap0),
        .o_lost       (lost0),
        .o_lowres_evt (lowres_evt0)
    );

    uets_channel u_chan1
    (
        .i_clk        (i_clk),
        .i_rst        (i_rst),
        .i_ce         (i_ce),
        .i_event      (i_event1),
        .i_io_update  (i_io_update),
        .i_read_ack   (read_ack1),
        .i_time       (time_now),
        .i_period_exp (period_exp),
        .i_period_tol (period_tol),
        .i_check_en   (ctrl[`UETS_CTRL_CHECK_BIT]),
        .o_stamp      (stamp1),
        .o_lowres     (),
        .o_missed     (),
        .o_capture    (cap1),
        .o_lost       (),
        .o_lowres_evt ()
    );

    assign wr_fire = aw_held & w_held & (wr_state == UETS_WR_IDLE);
    assign rd_fire = i_axi_arvalid & o_axi_arready;
    assign rd_idx  = i_axi_araddr[15:2];
    assign rd_off  = 4'(rd_idx - `UETS_IDX_EV0_B0);

    always_comb
    begin
        wr_known = 1'b1;
        case (aw_idx)
            `UETS_IDX_CTRL,
            `UETS_IDX_PERIOD,
            `UETS_IDX_TOL,
            `UETS_IDX_IRQ_STAT,
            `UETS_IDX_IRQ_MASK:
            begin
                wr_known = 1'b1;
            end
            default:
            begin
                // Writes to the read-only stamp bytes are accepted and ignored.
                wr_known = (aw_idx >= `UETS_IDX_EV0_B0) && (aw_idx <= `UETS_IDX_EV1_B0);
            end
        endcase
    end

    // Read mux: ten stamp bytes, count, status, channel 1's low byte, then control, period, tolerance and interrupt registers.
    always_comb
    begin
        rd_word  = 32'h0000_0000;
        rd_known = 1'b1;
        case (rd_idx)
            `UETS_IDX_EV0_MISSED:
            begin
                rd_word = {24'h00_0000, missed0};
            end
            `UETS_IDX_EV0_QUAL:
            begin
                rd_word = {31'h0000_0000, lowres0};
            end
            `UETS_IDX_EV1_B0:
            begin
                rd_word = {24'h00_0000, stamp1[7:0]};
            end
            `UETS_IDX_CTRL:
            begin
                rd_word = ctrl;
            end
            `UETS_IDX_PERIOD:
            begin
                rd_word = period_exp;
            end
            `UETS_IDX_TOL:
            begin
                rd_word = period_tol;
            end
            `UETS_IDX_IRQ_STAT:
            begin
                rd_word = {28'h000_0000, irq_stat};
            end
            `UETS_IDX_IRQ_MASK:
            begin
                rd_word = {28'h000_0000, irq_mask};
            end
            default:
            begin
                if ((rd_idx >= `UETS_IDX_EV0_B0) && (rd_idx <= `UETS_IDX_EV0_B9))
                begin
                    rd_word = {24'h00_0000, stamp0[{rd_off, 3'b000} +: 8]};
                end
                else
                begin
                    rd_known = 1'b0;
                end
            end
        endcase
    end

    // A read of any byte of a channel's stamp marks that stamp as read.
    assign read_ack0 = rd_fire && (rd_idx >= `UETS_IDX_EV0_B0) && (rd_idx <= `UETS_IDX_EV0_QUAL);
    assign read_ack1 = rd_fire && (rd_idx == `UETS_IDX_EV1_B0);

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            aw_held       <= 1'b0;
            aw_idx        <= 14'h0000;
            o_axi_awready <= 1'b1;
        end
        else if (i_ce)
        begin
            if (i_axi_awvalid && o_axi_awready)
            begin
                aw_held       <= 1'b1;
                aw_idx        <= i_axi_awaddr[15:2];
                o_axi_awready <= 1'b0;
            end
            else if (o_axi_bvalid && i_axi_bready)
            begin
                aw_held       <= 1'b0;
                o_axi_awready <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            w_held       <= 1'b0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            o_axi_wready <= 1'b1;
        end
        else if (i_ce)
        begin
            if (i_axi_wvalid && o_axi_wready)
            begin
                w_held       <= 1'b1;
                w_data       <= i_axi_wdata;
                w_strb       <= i_axi_wstrb;
                o_axi_wready <= 1'b0;
            end
            else if (o_axi_bvalid && i_axi_bready)
            begin
                w_held       <= 1'b0;
                o_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            wr_state     <= UETS_WR_IDLE;
            o_axi_bvalid <= 1'b0;
            o_axi_bresp  <= `UETS_RESP_OKAY;
        end
        else if (i_ce)
        begin
            case (wr_state)
                UETS_WR_IDLE:
                begin
                    if (wr_fire)
                    begin
                        o_axi_bvalid <= 1'b1;
                        o_axi_bresp  <= wr_known ? `UETS_RESP_OKAY : `UETS_RESP_SLVERR;
                        wr_state     <= UETS_WR_RESP;
                    end
                end
                UETS_WR_RESP:
                begin
                    if (i_axi_bready)
                    begin
                        o_axi_bvalid <= 1'b0;
                        wr_state     <= UETS_WR_IDLE;
                    end
                end
                default:
                begin
                    o_axi_bvalid <= 1'b0;
                    wr_state     <= UETS_WR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            ctrl       <= `UETS_CTRL_RST;
            period_exp <= `UETS_PERIOD_RST;
            period_tol <= `UETS_TOL_RST;
            irq_mask   <= `UETS_MASK_RST;
        end
        else if (i_ce && wr_fire)
        begin
            case (aw_idx)
                `UETS_IDX_CTRL:
                begin
                    ctrl <= apply_strb(ctrl, w_data, w_strb) & 32'h0000_0001;
                end
                `UETS_IDX_PERIOD:
                begin
                    period_exp <= apply_strb(period_exp, w_data, w_strb);
                end
                `UETS_IDX_TOL:
                begin
                    period_tol <= apply_strb(period_tol, w_data, w_strb);
                end
                `UETS_IDX_IRQ_MASK:
                begin
                    if (w_strb[0])
                    begin
                        irq_mask <= w_data[3:0];
                    end
                end
                default:
                begin
                    ctrl <= ctrl;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            rd_state      <= UETS_RD_IDLE;
            o_axi_arready <= 1'b1;
            o_axi_rvalid  <= 1'b0;
            o_axi_rdata   <= 32'h0000_0000;
            o_axi_rresp   <= `UETS_RESP_OKAY;
        end
        else if (i_ce)
        begin
            case (rd_state)
                UETS_RD_IDLE:
                begin
                    if (rd_fire)
                    begin
                        o_axi_arready <= 1'b0;
                        o_axi_rvalid  <= 1'b1;
                        o_axi_rdata   <= rd_word;
                        o_axi_rresp   <= rd_known ? `UETS_RESP_OKAY : `UETS_RESP_SLVERR;
                        rd_state      <= UETS_RD_DATA;
                    end
                end
                UETS_RD_DATA:
                begin
                    if (i_axi_rready)
                    begin
                        o_axi_rvalid  <= 1'b0;
                        o_axi_arready <= 1'b1;
                        rd_state      <= UETS_RD_IDLE;
                    end
                end
                default:
                begin
                    o_axi_rvalid  <= 1'b0;
                    o_axi_arready <= 1'b1;
                    rd_state      <= UETS_RD_IDLE;
                end
            endcase
        end
    end

    always_comb
    begin
        irq_set                    = 4'h0;
        irq_set[`UETS_IRQ_CAP0]    = cap0;
        irq_set[`UETS_IRQ_CAP1]    = cap1;
        irq_set[`UETS_IRQ_MISS0]   = lost0;
        irq_set[`UETS_IRQ_LOWRES0] = lowres_evt0;
        irq_clr                    = 4'h0;
        if (wr_fire && (aw_idx == `UETS_IDX_IRQ_STAT) && w_strb[0])
        begin
            irq_clr = w_data[3:0];
        end
    end

    // A new event in the same cycle as its clear keeps the bit set.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            irq_stat <= 4'h0;
            o_irq    <= 1'b0;
        end
        else if (i_ce)
        begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
            o_irq    <= |(irq_stat & irq_mask);
        end
    end
endmodule

// file: verif/uets_assertions.sv
`timescale 1ns/1ps
`include "uets_defs.svh"
module uets_checker
(
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_ce,
    input wire logic        i_axi_awvalid,
    input wire logic        o_axi_awready,
    input wire logic        i_axi_wvalid,
    input wire logic        o_axi_wready,
    input wire logic [1:0]  o_axi_bresp,
    input wire logic        o_axi_bvalid,
    input wire logic        i_axi_bready,
    input wire logic [15:0] i_axi_araddr,
    input wire logic        i_axi_arvalid,
    input wire logic        o_axi_arready,
    input wire logic [31:0] o_axi_rdata,
    input wire logic [1:0]  o_axi_rresp,
    input wire logic        o_axi_rvalid,
    input wire logic        i_axi_rready,
    input wire logic        o_irq
);
    logic [13:0] idx;
    logic        mapped;
    logic        ar_take;
    assign idx = i_axi_araddr[15:2];
    assign mapped = (idx >= 14'h3A14 && idx <= 14'h3A20) || (idx >= 14'h3A30 && idx <= 14'h3A34);
    assign ar_take = i_axi_arvalid && o_axi_arready && i_ce;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    rvalid_hold_a: assert property (o_axi_rvalid && !i_axi_rready && i_ce |=> o_axi_rvalid && $stable(o_axi_rdata))
        else $error("read data dropped before rready");
    bvalid_hold_a: assert property (o_axi_bvalid && !i_axi_bready && i_ce |=> o_axi_bvalid && $stable(o_axi_bresp))
        else $error("write response dropped before bready");
    read_answer_a: assert property (ar_take |=> o_axi_rvalid)
        else $error("read not answered in one cycle");
    read_busy_a: assert property (o_axi_rvalid |-> !o_axi_arready)
        else $error("read address taken while data pending");
    write_busy_a: assert property (o_axi_bvalid |-> !o_axi_awready && !o_axi_wready)
        else $error("write taken while response pending");
    write_answer_a: assert property (i_axi_awvalid && o_axi_awready && i_axi_wvalid && o_axi_wready && i_ce
        |-> ##[1:2] o_axi_bvalid)
        else $error("write not answered");
    unmapped_read_a: assert property (ar_take && !mapped |=> o_axi_rresp == `UETS_RESP_SLVERR && o_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    mapped_read_a: assert property (ar_take && mapped |=> o_axi_rresp == `UETS_RESP_OKAY)
        else $error("mapped read refused");
    reset_idle_a: assert property (disable iff (1'b0) i_rst && i_ce |=> !o_axi_bvalid && !o_axi_rvalid && !o_irq)
        else $error("outputs busy after reset");
    cover property (o_axi_rvalid && o_axi_rresp == `UETS_RESP_SLVERR);
    cover property ($rose(o_irq));
    cover property (o_axi_bvalid && i_axi_bready);
endmodule
bind uets_top uets_checker u_chk (.*);

// file: verif/uets_evt_src.sv
`timescale 1ns/1ps
module uets_evt_src
(
    input  wire logic       i_clk,
    input  wire logic [1:0] i_fire,
    output logic            o_event0,
    output logic            o_event1
);
    // A request gives one high cycle, so each request is a fresh rising edge.
    always_ff @(posedge i_clk)
    begin
        o_event0 <= i_fire[0];
        o_event1 <= i_fire[1];
    end
endmodule

// file: verif/tb_top.sv
`timescale 1ns/1ps
`include "uets_defs.svh"
module tb_top;
    import uets_pkg::*;
    logic        i_clk, i_rst, i_ce, i_event0, i_event1, i_io_update;
    logic [15:0] i_axi_awaddr, i_axi_araddr;
    logic        i_axi_awvalid, i_axi_wvalid, i_axi_bready, i_axi_arvalid, i_axi_rready;
    uets_word_t  i_axi_wdata, o_axi_rdata, d;
    logic [3:0]  i_axi_wstrb;
    logic        o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid, o_irq;
    logic [1:0]  o_axi_bresp, o_axi_rresp, fire, rsp;
    uets_stamp_t s, s2, off, t;
    int          num_errors, checks, cyc, miss, p, tol, g, k;
    uets_top uut (.*);
    uets_evt_src u_src (.i_clk(i_clk), .i_fire(fire), .o_event0(i_event0), .o_event1(i_event1));
    initial
    begin
        i_clk = 0;
        forever #25 i_clk = ~i_clk;
    end
    always @(posedge i_clk) cyc <= i_rst ? 0 : cyc + 1;
    task automatic give_verdict;
        if (num_errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input uets_stamp_t got, input uets_stamp_t exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input int i, output uets_word_t v);
        int n;
        @(posedge i_clk);
        i_axi_araddr <= 16'(i * 4);
        i_axi_arvalid <= 1'b1;
        i_axi_rready <= 1'b1;
        for (n = 0; n < 50 && o_axi_rvalid !== 1'b1; n++)
        begin
            @(posedge i_clk);
            if (i_axi_arvalid && o_axi_arready) i_axi_arvalid <= 1'b0;
        end
        v = o_axi_rdata;
        rsp = o_axi_rresp;
        i_axi_rready <= 1'b0;
        if (n == 50) num_errors++;
    endtask
    task automatic wr(input int i, input uets_word_t v);
        int n;
        @(posedge i_clk);
        i_axi_awaddr <= 16'(i * 4);
        i_axi_wdata <= v;
        {i_axi_awvalid, i_axi_wvalid, i_axi_bready} <= 3'h7;
        for (n = 0; n < 50 && o_axi_bvalid !== 1'b1; n++)
        begin
            @(posedge i_clk);
            if (i_axi_awvalid && o_axi_awready) i_axi_awvalid <= 1'b0;
            if (i_axi_wvalid && o_axi_wready) i_axi_wvalid <= 1'b0;
        end
        rsp = o_axi_bresp;
        i_axi_bready <= 1'b0;
        if (n == 50) num_errors++;
    endtask
    task automatic pulse(input logic [1:0] f, input logic u);
        @(posedge i_clk);
        fire <= f;
        i_io_update <= u;
        if (f != 2'h0) t = 80'(cyc);
        @(posedge i_clk);
        fire <= 2'h0;
        i_io_update <= 1'b0;
    endtask
    task automatic stamp(output uets_stamp_t v);
        for (int j = 0; j < 10; j++)
        begin
            rd(`UETS_IDX_EV0_B0 + j, d);
            v[8 * j +: 8] = d[7:0];
        end
    endtask
    function automatic logic lowres(input int gap, input int per, input int tl);
        return (gap > per + tl) || (gap + tl < per);
    endfunction
    initial
    begin
        {i_rst, i_ce, i_io_update, fire, i_axi_wstrb} = {1'b1, 1'b1, 1'b0, 2'h0, 4'hF};
        {i_axi_awaddr, i_axi_araddr, i_axi_wdata} = '0;
        {i_axi_awvalid, i_axi_wvalid, i_axi_bready, i_axi_arvalid, i_axi_rready} = '0;
        void'($urandom(34));
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        rd('h3A40, d);
        chk(d, 0);
        chk(rsp, `UETS_RESP_SLVERR);
        rd(`UETS_IDX_EV0_MISSED, d);
        chk(d, 0);
        pulse(2'h1, 0);
        pulse(2'h0, 1);
        stamp(s);
        off = 80'h2;
        chk(s, t + off);
        pulse(2'h1, 0);
        pulse(2'h0, 1);
        pulse(2'h1, 0);
        pulse(2'h0, 1);
        stamp(s);
        chk(s, t + off);
        miss = 1;
        rd(`UETS_IDX_EV0_MISSED, d);
        chk(d, miss);
        wr(`UETS_IDX_EV0_B0, 32'hFF);
        chk(rsp, `UETS_RESP_OKAY);
        pulse(2'h1, 0);
        pulse(2'h1, 0);
        stamp(s2);
        chk(s2, s);
        pulse(2'h0, 1);
        stamp(s);
        chk(s, t + off);
        miss++;
        rd(`UETS_IDX_EV0_MISSED, d);
        chk(d, miss);
        pulse(2'h3, 0);
        pulse(2'h0, 1);
        rd(`UETS_IDX_EV1_B0, d);
        chk(d, 80'((t + off) & 80'hFF));
        rd(`UETS_IDX_EV0_B0, d);
        chk(d, 80'((t + off) & 80'hFF));
        p = 10 + $urandom % 30;
        tol = 1 + $urandom % 4;
        wr(`UETS_IDX_PERIOD, p);
        wr(`UETS_IDX_TOL, tol);
        wr(`UETS_IDX_CTRL, 1);
        for (k = 0; k < 8; k++)
        begin
            g = (k == 0) ? p - tol : (k == 1) ? p + tol : (k == 2) ? p - tol - 1 : (k == 3) ? p + tol + 1
                : p - tol - 2 + $urandom % (2 * tol + 5);
            pulse(2'h1, 0);
            repeat (g - 2) @(posedge i_clk);
            pulse(2'h1, 0);
            pulse(2'h0, 1);
            miss++;
            rd(`UETS_IDX_EV0_QUAL, d);
            chk(d[0], lowres(g, p, tol));
            stamp(s);
            if (d[0] === 1'b0) chk(s, t + off);
        end
        rd(`UETS_IDX_EV0_MISSED, d);
        chk(d, miss);
        wr(`UETS_IDX_IRQ_STAT, 32'hF);
        wr(`UETS_IDX_IRQ_MASK, 32'h1);
        repeat (3) @(posedge i_clk);
        chk(o_irq, 0);
        pulse(2'h1, 0);
        repeat (4) @(posedge i_clk);
        chk(o_irq, 1);
        wr(`UETS_IDX_IRQ_STAT, 32'h1);
        repeat (3) @(posedge i_clk);
        chk(o_irq, 0);
        wr(`UETS_IDX_IRQ_MASK, 32'h4);
        repeat (3) @(posedge i_clk);
        chk(o_irq, 0);
        repeat (260) pulse(2'h1, 0);
        repeat (3) @(posedge i_clk);
        chk(o_irq, 1);
        rd(`UETS_IDX_EV0_MISSED, d);
        chk(d, `UETS_MISSED_MAX);
        give_verdict;
    end
    initial
    begin
        repeat (20000) @(posedge i_clk);
        num_errors++;
        give_verdict;
    end
endmodule
